// [rtl/adc_output_port_config.sv]
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module adc_output_port_config (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire adc_port_pkg::apb_req_t apb_req,
	output adc_port_pkg::apb_rsp_t      apb_rsp,
	input  wire logic                   conv_start,
	input  wire logic                   result_valid,
	input  wire logic [15:0]            result,
	input  wire logic                   cs_n_pin,
	input  wire logic                   sclk_in,
	output logic                        sclk_out,
	output logic                        sclk_oe_n,
	output logic                        frame_sync,
	output logic                        frame_sync_oe_n,
	input  wire logic [15:0]            d_in,
	output logic [15:0]                 d_out,
	output logic [15:0]                 d_oe_n
);
	import adc_port_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [SYNC_N-1:0] pin_raw;
	logic [SYNC_N-1:0] s1_q;
	logic [SYNC_N-1:0] s2_q;
	logic [SYNC_N-1:0] s3_q;
	logic [SYNC_N-1:0] filt_q;
	logic [SYNC_N-1:0] filt_d;
	logic [SYNC_N-1:0] prev_q;
	assign pin_raw = {cs_n_pin, sclk_in, d_in[PIN_DAISY],
		d_in[PIN_DIV1], d_in[PIN_DIV0]};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			always_comb begin
				filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q[gi]   <= SYNC_RESET[gi];
					s2_q[gi]   <= SYNC_RESET[gi];
					s3_q[gi]   <= SYNC_RESET[gi];
					filt_q[gi] <= SYNC_RESET[gi];
					prev_q[gi] <= SYNC_RESET[gi];
				end else begin
					s1_q[gi]   <= pin_raw[gi];
					s2_q[gi]   <= s1_q[gi];
					s3_q[gi]   <= s2_q[gi];
					filt_q[gi] <= filt_d[gi];
					prev_q[gi] <= filt_q[gi];
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////
	// Configuration decode
	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic              serial;
	logic              master;
	logic              slave;
	logic              rac;
	logic [1:0]        div_code;
	logic [7:0]        half_len;
	logic              cs_low;
	logic              cs_fall;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              slave_edge;
	assign serial   = ctrl_q[CTRL_PORT_TYPE];
	assign master   = serial & ~ctrl_q[CTRL_CLK_SRC];
	assign slave    = serial & ctrl_q[CTRL_CLK_SRC];
	assign rac      = master & ~ctrl_q[CTRL_RDC];
	// Divider pins only count in master read-after mode
	assign div_code = rac ? {filt_q[SY_DIV1], filt_q[SY_DIV0]}
		: 2'h0;
	assign cs_low   = ~filt_q[SY_CS];
	assign cs_fall  = cs_low & prev_q[SY_CS];
	assign sclk_rise  = filt_q[SY_SCLK] & ~prev_q[SY_SCLK];
	assign sclk_fall  = ~filt_q[SY_SCLK] & prev_q[SY_SCLK];
	assign slave_edge = ctrl_q[CTRL_SCLK_INV] ? sclk_fall
		: sclk_rise;

	always_comb begin
		case (div_code)
			2'h0: half_len = SCLK_HALF_0;
			2'h1: half_len = SCLK_HALF_1;
			2'h2: half_len = SCLK_HALF_2;
			2'h3: half_len = SCLK_HALF_3;
			default: half_len = SCLK_HALF_0;
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	// Result store and coding
	logic [15:0] cur_q;
	logic [15:0] cur_d;
	logic [15:0] prv_q;
	logic [15:0] prv_d;
	logic [15:0] cur_coded;
	logic [15:0] prv_coded;
	always_comb begin
		cur_d = cur_q;
		prv_d = prv_q;
		if (result_valid) begin
			prv_d = cur_q;
			cur_d = result;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_q <= 16'h0000;
			prv_q <= 16'h0000;
		end else begin
			cur_q <= cur_d;
			prv_q <= prv_d;
		end
	end
	// MSB inverted for twos complement
	assign cur_coded = {cur_q[15] ^ ~ctrl_q[CTRL_CODE_FMT],
		cur_q[14:0]};
	assign prv_coded = {prv_q[15] ^ ~ctrl_q[CTRL_CODE_FMT],
		prv_q[14:0]};

	////////////////////////////////////////////////////////////////////////
	// Serial engine
	ser_state_t  st_q;
	ser_state_t  st_d;
	logic [15:0] sh_q;
	logic [15:0] sh_d;
	logic [3:0]  bit_q;
	logic [3:0]  bit_d;
	logic [7:0]  div_q;
	logic [7:0]  div_d;
	logic        sclk_int_q;
	logic        sclk_int_d;
	logic        sync_act_q;
	logic        sync_act_d;
	logic        tick;
	logic        load_m;
	assign tick   = (div_q == half_len - 8'h01);
	// In master mode, read during conversion sends the previous word at conversion start
	assign load_m = ctrl_q[CTRL_RDC] ? conv_start : result_valid;
	always_comb begin
		st_d       = st_q;
		sh_d       = sh_q;
		bit_d      = bit_q;
		div_d      = tick ? 8'h00 : div_q + 8'h01;
		sclk_int_d = sclk_int_q;
		sync_act_d = sync_act_q;
		case (st_q)
			ST_IDLE: begin
				div_d = 8'h00;
				if (master && load_m) begin
					sh_d       = ctrl_q[CTRL_RDC] ? prv_coded
						: (result_valid ? {result[15] ^
						~ctrl_q[CTRL_CODE_FMT], result[14:0]}
						: cur_coded);
					bit_d      = 4'h0;
					sclk_int_d = 1'b0;
					sync_act_d = 1'b1;
					st_d       = ST_LOW;
				end else if (slave && cs_fall) begin
					sh_d  = cur_coded;
					bit_d = 4'h0;
					st_d  = ST_SLAVE;
				end
			end
			ST_LOW: begin
				if (tick) begin
					sclk_int_d = 1'b1;
					st_d       = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (tick) begin
					sclk_int_d = 1'b0;
					if (bit_q == LAST_BIT) begin
						sync_act_d = 1'b0;
						st_d       = ST_IDLE;
					end else begin
						sh_d  = {sh_q[14:0], 1'b0};
						bit_d = bit_q + 4'h1;
						st_d  = ST_LOW;
					end
				end
			end
			ST_SLAVE: begin
				div_d = 8'h00;
				if (!cs_low) begin
					st_d = ST_IDLE;
				end else if (slave_edge) begin
					// Daisy bits follow the word
					sh_d  = {sh_q[14:0], filt_q[SY_DAISY]};
					bit_d = bit_q + 4'h1;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		if (!serial) begin
			st_d       = ST_IDLE;
			sclk_int_d = 1'b0;
			sync_act_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= ST_IDLE;
			sh_q       <= 16'h0000;
			bit_q      <= 4'h0;
			div_q      <= 8'h00;
			sclk_int_q <= 1'b0;
			sync_act_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			sh_q       <= sh_d;
			bit_q      <= bit_d;
			div_q      <= div_d;
			sclk_int_q <= sclk_int_d;
			sync_act_q <= sync_act_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Pin drivers
	logic [15:0] word;
	logic [15:0] dout_d;
	logic [15:0] doe_d;
	logic        sclk_d;
	logic        sclk_oe_d;
	logic        sync_d;
	logic        sync_oe_d;
	assign word = ctrl_q[CTRL_BYTE_ORD] ? {cur_coded[7:0], cur_coded[15:8]}
		: cur_coded;

	always_comb begin
		dout_d    = word;
		doe_d     = 16'hFFFF;
		sclk_d    = 1'b0;
		sclk_oe_d = 1'b1;
		sync_d    = 1'b0;
		sync_oe_d = 1'b1;
		if (!serial) begin
			doe_d = {16{~cs_low}};
		end else begin
			// Other data pins float, except D0 and D1, which are always driven
			dout_d[PIN_SDO] = sh_q[15];
			doe_d[PIN_SDO]  = ~(master | cs_low);
			if (master) begin
				sclk_d    = sclk_int_q ^ ctrl_q[CTRL_SCLK_INV];
				sclk_oe_d = 1'b0;
				sync_d    = sync_act_q ^ ctrl_q[CTRL_FRAME_POL];
				sync_oe_d = 1'b0;
			end
		end
		doe_d[1:0] = 2'h0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d_out           <= 16'h0000;
			d_oe_n          <= 16'hFFFF;
			sclk_out        <= 1'b0;
			sclk_oe_n       <= 1'b1;
			frame_sync      <= 1'b0;
			frame_sync_oe_n <= 1'b1;
		end else begin
			d_out           <= dout_d;
			d_oe_n          <= doe_d;
			sclk_out        <= sclk_d;
			sclk_oe_n       <= sclk_oe_d;
			frame_sync      <= sync_d;
			frame_sync_oe_n <= sync_oe_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// APB slave
	apb_rsp_t    rsp_d;
	logic        access;
	logic [31:0] status;
	assign access = apb_req.psel & apb_req.penable;
	always_comb begin
		status = 32'h0000_0000;
		status[STAT_BUSY]   = (st_q != ST_IDLE);
		status[STAT_SERIAL] = serial;
		status[STAT_DIV_HI:STAT_DIV_LO] = div_code;
		status[STAT_MASTER] = master;
	end
	always_comb begin
		ctrl_d        = ctrl_q;
		rsp_d         = apb_rsp;
		rsp_d.pready  = access & ~apb_rsp.pready;
		rsp_d.pslverr = 1'b0;
		rsp_d.prdata  = 32'h0000_0000;
		if (access && !apb_rsp.pready) begin
			case (apb_req.paddr)
				OFS_CTRL:   rsp_d.prdata = {25'h0000000, ctrl_q};
				OFS_STATUS: rsp_d.prdata = status;
				OFS_RESULT: rsp_d.prdata = {16'h0000, cur_coded};
				default:    rsp_d.pslverr = 1'b1;
			endcase
		end
		if (access && apb_rsp.pready && apb_req.pwrite
				&& apb_req.paddr == OFS_CTRL) begin
			ctrl_d = apb_req.pwdata[CTRL_W-1:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= CTRL_RESET;
			apb_rsp <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			apb_rsp <= rsp_d;
		end
	end
endmodule

// [rtl/adc_port_pkg.sv]
package adc_port_pkg;

	// Clock and word sizes
	localparam int          CLK_NS    = 50;
	localparam int          RESULT_W  = 16;
	localparam int          ADDR_W    = 12;
	localparam int          DATA_W    = 32;

	// Least internal serial clock periods per divider code
	localparam int          SCLK_MIN_NS_0 = 8;
	localparam int          SCLK_MIN_NS_1 = 16;
	localparam int          SCLK_MIN_NS_2 = 32;
	localparam int          SCLK_MIN_NS_3 = 64;

	function automatic logic [7:0] half_cycles(input int ns);
		int c;
		c = (ns + 2 * CLK_NS - 1) / (2 * CLK_NS);
		if (c < 1) begin
			c = 1;
		end
		return c[7:0];
	endfunction

	localparam logic [7:0]  SCLK_HALF_0 = half_cycles(SCLK_MIN_NS_0);
	localparam logic [7:0]  SCLK_HALF_1 = half_cycles(SCLK_MIN_NS_1);
	localparam logic [7:0]  SCLK_HALF_2 = half_cycles(SCLK_MIN_NS_2);
	localparam logic [7:0]  SCLK_HALF_3 = half_cycles(SCLK_MIN_NS_3);

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h008;

	// Control register fields
	localparam int          CTRL_W         = 7;
	localparam int          CTRL_BYTE_ORD  = 0;
	localparam int          CTRL_CODE_FMT  = 1;
	localparam int          CTRL_PORT_TYPE = 2;
	localparam int          CTRL_CLK_SRC   = 3;
	localparam int          CTRL_FRAME_POL = 4;
	localparam int          CTRL_SCLK_INV  = 5;
	localparam int          CTRL_RDC       = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h02;

	// Status register fields
	localparam int          STAT_BUSY   = 0;
	localparam int          STAT_SERIAL = 1;
	localparam int          STAT_DIV_LO = 2;
	localparam int          STAT_DIV_HI = 3;
	localparam int          STAT_MASTER = 4;

	// Data pin roles
	localparam int          PIN_DIV0  = 2;
	localparam int          PIN_DIV1  = 3;
	localparam int          PIN_DAISY = 7;
	localparam int          PIN_SDO   = 8;

	// Synchronised pin vector
	localparam int          SYNC_N    = 5;
	localparam int          SY_DIV0   = 0;
	localparam int          SY_DIV1   = 1;
	localparam int          SY_DAISY  = 2;
	localparam int          SY_SCLK   = 3;
	localparam int          SY_CS     = 4;
	localparam logic [SYNC_N-1:0] SYNC_RESET = 5'h10;

	localparam logic [3:0]  LAST_BIT  = 4'hF;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LOW   = 2'b01,
		ST_HIGH  = 2'b10,
		ST_SLAVE = 2'b11
	} ser_state_t;

endpackage

// [verification/adc_host_model.sv]
`timescale 1ns/1ps
module adc_host_model (
	input wire logic pclk,
	input wire logic inv,
	input wire logic pol,
	input wire logic sclk_out,
	input wire logic frame_sync,
	input wire logic sdo,
	output logic     cs_n_pin,
	output logic     sclk_in,
	output logic [15:0] word,
	output int       frames,
	output int       gap
);
	logic fa;
	logic fa_p;
	logic ck_p;
	int   since;
	initial begin
		cs_n_pin = 1'b1;
		sclk_in = 1'b0;
		frames = 0;
		since = 0;
		fa_p = 1'b0;
		ck_p = 1'b0;
	end
	assign fa = frame_sync != pol;
	// Master frames, taken on internal rising clock
	always @(posedge pclk) begin
		fa_p <= fa;
		ck_p <= sclk_out ^ inv;
		since <= since + 1;
		if (fa_p && !fa) begin
			frames <= frames + 1;
		end
		if (fa && (sclk_out ^ inv) && !ck_p) begin
			word <= {word[14:0], sdo};
			gap <= since;
			since <= 1;
		end
	end
	task automatic select(input logic v);
		@(posedge pclk);
		cs_n_pin <= v;
	endtask
	// Slave read, host makes the clock
	task automatic slave_read(output logic [15:0] w);
		int i;
		@(posedge pclk);
		sclk_in <= inv;
		repeat (8) @(posedge pclk);
		cs_n_pin <= 1'b0;
		repeat (8) @(posedge pclk);
		for (i = 0; i < 16; i++) begin
			w = {w[14:0], sdo};
			sclk_in <= !inv;
			repeat (8) @(posedge pclk);
			sclk_in <= inv;
			repeat (8) @(posedge pclk);
		end
		cs_n_pin <= 1'b1;
	endtask
endmodule

// [verification/adc_output_port_config_tb_top.sv]
`timescale 1ns/1ps
module adc_output_port_config_tb_top;
	import adc_port_pkg::*;
	logic        pclk, presetn, conv_start, result_valid, cs_n_pin;
	logic        sclk_in, sclk_out, sclk_oe_n, frame_sync, frame_sync_oe_n;
	logic        er;
	apb_req_t    apb_req;
	apb_rsp_t    apb_rsp;
	logic [15:0] result, d_in, d_out, d_oe_n, pins, hw, w;
	logic [31:0] rd;
	logic [6:0]  ctl;
	int          frames, gap, miscompares, n_tests;
	assign d_in = (d_out & ~d_oe_n) | (pins & d_oe_n);
	adc_output_port_config u_adc_output_port_config (
		.pclk           (pclk),
		.presetn        (presetn),
		.apb_req        (apb_req),
		.apb_rsp        (apb_rsp),
		.conv_start     (conv_start),
		.result_valid   (result_valid),
		.result         (result),
		.cs_n_pin       (cs_n_pin),
		.sclk_in        (sclk_in),
		.sclk_out       (sclk_out),
		.sclk_oe_n      (sclk_oe_n),
		.frame_sync     (frame_sync),
		.frame_sync_oe_n(frame_sync_oe_n),
		.d_in           (d_in),
		.d_out          (d_out),
		.d_oe_n         (d_oe_n)
	);
	adc_host_model u_adc_host_model (.pclk(pclk), .inv(ctl[CTRL_SCLK_INV]),
		.pol(ctl[CTRL_FRAME_POL]), .sclk_out(sclk_out),
		.frame_sync(frame_sync), .sdo(d_out[PIN_SDO]), .cs_n_pin(cs_n_pin),
		.sclk_in(sclk_in), .word(hw), .frames(frames), .gap(gap));
	always #25 pclk = ~pclk;
	////////////////
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t data %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task automatic setc(input logic [6:0] c);
		ctl = c;
		apb(1'b1, OFS_CTRL, {25'h0, c});
	endtask
	task automatic send(input logic [15:0] r);
		@(posedge pclk);
		result <= r;
		result_valid <= 1'b1;
		@(posedge pclk);
		result_valid <= 1'b0;
	endtask
	function automatic logic [15:0] coded(input logic [15:0] r,
		input logic [6:0] c);
		return c[CTRL_CODE_FMT] ? r : r ^ 16'h8000;
	endfunction
	////////////////
	task automatic t_regs;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk32(rd, 32'h00000002);
		apb(1'b0, 12'h00C, 32'h0);
		chk32({rd[30:0], er}, 32'h00000001);
	endtask
	task automatic t_par;
		logic [15:0] k;
		int i;
		u_adc_host_model.select(1'b0);
		for (i = 0; i < 4; i++) begin
			setc(i[6:0]);
			send(16'h81C3);
			repeat (8) @(posedge pclk);
			k = coded(16'h81C3, ctl);
			chk16(d_out, ctl[0] ? {k[7:0], k[15:8]} : k);
			chk16(d_oe_n, 16'h0000);
			apb(1'b0, OFS_RESULT, 32'h0);
			chk32(rd, {16'h0, k});
		end
		u_adc_host_model.select(1'b1);
	endtask
	task automatic t_master(input logic [6:0] c, input logic [1:0] dv,
		input logic [15:0] r);
		int f0;
		int n;
		logic [15:0] p;
		setc(c);
		repeat (4) @(posedge pclk);
		f0 = frames;
		p = c[CTRL_RDC] ? result : r;
		send(r);
		conv_start <= c[CTRL_RDC];
		@(posedge pclk);
		conv_start <= 1'b0;
		n = 0;
		while (frames == f0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk32(frames - f0, 32'd1);
		chk16(hw, coded(p, c));
		chk32(gap, 32'd2);
		repeat (6) @(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk32(rd & 32'h1E, {28'h1, dv, 2'b10});
	endtask
	task automatic t_slave(input logic [6:0] c);
		setc(c);
		send(16'hC35A);
		u_adc_host_model.slave_read(w);
		chk16(w, coded(16'hC35A, c));
	endtask
	////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		apb_req = '0;
		conv_start = 1'b0;
		result_valid = 1'b0;
		result = 16'h0000;
		pins = 16'h0008;
		ctl = CTRL_RESET;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_par;
		t_master(7'h04, 2'b10, 16'h5A3C);
		t_master(7'h76, 2'b00, 16'h1234);
		t_slave(7'h0C);
		t_slave(7'h2E);
		wrap_up;
	end
	initial begin
		#200000;
		miscompares++;
		wrap_up;
	end
endmodule
bind adc_output_port_config adc_port_checker u_adc_port_checker (
	.pclk           (pclk),
	.presetn        (presetn),
	.apb_req        (apb_req),
	.apb_rsp        (apb_rsp),
	.cs_n_pin       (cs_n_pin),
	.sclk_out       (sclk_out),
	.sclk_oe_n      (sclk_oe_n),
	.frame_sync     (frame_sync),
	.frame_sync_oe_n(frame_sync_oe_n),
	.d_oe_n         (d_oe_n)
);

// [verification/adc_port_checker.sv]
`timescale 1ns/1ps
module adc_port_checker (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire adc_port_pkg::apb_req_t apb_req,
	input wire adc_port_pkg::apb_rsp_t apb_rsp,
	input wire logic                   cs_n_pin,
	input wire logic                   sclk_out,
	input wire logic                   sclk_oe_n,
	input wire logic                   frame_sync,
	input wire logic                   frame_sync_oe_n,
	input wire logic [15:0]            d_oe_n
);
	import adc_port_pkg::*;
	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic              ser;
	logic              src;
	logic              mst;
	// Shadow of the control register
	always_comb begin
		ctrl_d = ctrl_q;
		if (apb_req.psel && apb_req.penable && apb_rsp.pready &&
		    apb_req.pwrite && apb_req.paddr == OFS_CTRL) begin
			ctrl_d = apb_req.pwdata[CTRL_W-1:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end
	assign ser = ctrl_q[CTRL_PORT_TYPE];
	assign src = ctrl_q[CTRL_CLK_SRC];
	assign mst = ser && !src;
	////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	low_pins_a: assert property ($past(presetn) |-> d_oe_n[1:0] == 2'b00)
		else $error("D0/D1 not driven");
	pins_float_a: assert property (ser [*3] |->
		d_oe_n[15:9] == 7'h7F && d_oe_n[7:2] == 6'h3F)
		else $error("serial spare pins driven");
	par_drive_a: assert property ((!cs_n_pin && !ser) [*6] |->
		d_oe_n == 16'h0000) else $error("parallel bus not driven");
	master_clk_a: assert property (mst [*3] |->
		!sclk_oe_n && !frame_sync_oe_n) else $error("master not driving");
	slave_clk_a: assert property ((ser && src) [*3] |-> sclk_oe_n)
		else $error("slave drives clock");
	frame_pol_a: assert property ((mst && $stable(ctrl_q)) [*3] ##0
		($changed(sclk_out) && sclk_out != ctrl_q[CTRL_SCLK_INV]) |->
		frame_sync != ctrl_q[CTRL_FRAME_POL])
		else $error("clock runs outside frame");
	clk_idle_a: assert property ((mst && $stable(ctrl_q) &&
		frame_sync == ctrl_q[CTRL_FRAME_POL]) [*3] |->
		sclk_out == ctrl_q[CTRL_SCLK_INV]) else $error("idle clock level");
	slave_out_a: assert property ((ser && src && !cs_n_pin) [*8] |->
		!d_oe_n[PIN_SDO]) else $error("slave output not driven");
endmodule
